// File: logic/thermal_status_pkg.sv
package thermal_status_pkg;

    // Serial slave address, upper seven bits of the address byte
    localparam logic [6:0] SLAVE_ADDR = 7'h4D;

    // Command codes that select a register
    localparam logic [7:0] CMD_OVERTEMP_STATUS = 8'h01;
    localparam logic [7:0] CMD_DIODE_FAULT_STATUS = 8'h02;
    localparam logic [7:0] CMD_OVERTEMP_SUPPRESS = 8'h03;

    // Implemented bits of each register; the rest are reserved and read zero
    localparam logic [7:0] OVERTEMP_BITS = 8'h39;
    localparam logic [7:0] FAULT_BITS = 8'h7E;
    localparam logic [7:0] SUPPRESS_BITS = 8'h39;

    // Reset values, and the value read for an unmapped command code
    localparam logic [7:0] OVERTEMP_STATUS_RST = 8'h00;
    localparam logic [7:0] DIODE_FAULT_STATUS_RST = 8'h00;
    localparam logic [7:0] OVERTEMP_SUPPRESS_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Bits per serial byte
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Serial slave states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_CMD = 4'b0011,
        ST_CMD_ACK = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RDATA_ACK = 4'b1000
    } smb_state_t;

    // One conversion result from the measurement sequencer
    typedef struct packed {
        logic valid;
        logic [2:0] channel;
        logic above_limit;
        logic diode_fault;
    } conv_result_t;

endpackage

// File: logic/thermal_status_reporting.sv
`timescale 1ns/100ps
// Summary of operation
// - Channel 1 above its overtemperature limit sets overtemperature status bit 0.
// - Channels 4, 5, 6 above limit set status bits 3, 4, 5; others reserved.
// - Open or supply-tied diode on channel n sets fault status bit n.
// - Slave answers address 1001101 in bits 7..1; bit 0 selects read or write.
// - Faulted channels are skipped by the sequence yet still reported as faulted.
// - A set suppress bit keeps its channel from asserting the overtemperature output.
module thermal_status_reporting (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Measurement sequencer
    input wire thermal_status_pkg::conv_result_t i_conv,
    output logic [7:0] o_skip_channel,
    // Serial bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // Alarm output
    output logic o_overtemp_out
);
    import thermal_status_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the third stage only serves edge detection
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end else begin
            scl_sync <= {scl_sync[1:0], i_scl};
            sda_sync <= {sda_sync[1:0], i_sda};
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    // Edges are judged on the second and third stages only
    assign scl_rise = scl_sync[1] & ~scl_sync[2];
    assign scl_fall = ~scl_sync[1] & scl_sync[2];
    assign bus_start = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
    assign bus_stop = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];

    ////////////////////////////////////////////////////////////////////////////
    // Status and suppress registers
    logic [7:0] overtemp_status;
    logic [7:0] diode_fault_status;
    logic [7:0] overtemp_suppress;
    logic overtemp_out;
    logic [7:0] next_overtemp_status;
    logic [7:0] next_diode_fault_status;
    logic [7:0] next_overtemp_suppress;
    logic next_overtemp_out;
    logic reg_write;
    logic [7:0] reg_wdata;
    logic [7:0] cmd;

    // Each conversion refreshes its channel; reserved bits are masked off
    always_comb begin
        next_overtemp_status = overtemp_status;
        next_diode_fault_status = diode_fault_status;
        next_overtemp_suppress = overtemp_suppress;
        if (i_conv.valid && i_conv.channel != 3'h0 && i_conv.channel != 3'h7) begin
            next_diode_fault_status[i_conv.channel] = i_conv.diode_fault;
            // A faulted channel is not measured, so its limit state holds
            if (!i_conv.diode_fault && !diode_fault_status[i_conv.channel]) begin
                next_overtemp_status[3'(i_conv.channel - 3'h1)] = i_conv.above_limit;
            end
        end
        next_overtemp_status = next_overtemp_status & OVERTEMP_BITS;
        next_diode_fault_status = next_diode_fault_status & FAULT_BITS;
        if (reg_write && cmd == CMD_OVERTEMP_SUPPRESS) begin
            next_overtemp_suppress = reg_wdata & SUPPRESS_BITS;
        end
        // Registered, so the alarm trails the status by one cycle
        next_overtemp_out = |(overtemp_status & ~overtemp_suppress);
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            overtemp_status <= OVERTEMP_STATUS_RST;
            diode_fault_status <= DIODE_FAULT_STATUS_RST;
            overtemp_suppress <= OVERTEMP_SUPPRESS_RST;
            overtemp_out <= 1'b0;
            o_skip_channel <= 8'h00;
        end else begin
            overtemp_status <= next_overtemp_status;
            diode_fault_status <= next_diode_fault_status;
            overtemp_suppress <= next_overtemp_suppress;
            overtemp_out <= next_overtemp_out;
            o_skip_channel <= next_diode_fault_status;
        end
    end

    assign o_overtemp_out = overtemp_out;

    ////////////////////////////////////////////////////////////////////////////
    // Register read decode
    function automatic logic [7:0] read_reg(input logic [7:0] sel, input logic [7:0] ot,
                                            input logic [7:0] df, input logic [7:0] sup);
        unique case (sel)
            CMD_OVERTEMP_STATUS: read_reg = ot;
            CMD_DIODE_FAULT_STATUS: read_reg = df;
            CMD_OVERTEMP_SUPPRESS: read_reg = sup;
            default: read_reg = UNMAPPED_READ;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Serial slave
    smb_state_t state;
    smb_state_t next_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [7:0] next_cmd;
    logic sda_oe;
    logic next_sda_oe;

    // Data bits move on falling clock and are sampled on rising clock
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_cmd = cmd;
        next_sda_oe = sda_oe;
        reg_write = 1'b0;
        reg_wdata = shift;
        if (bus_stop) begin
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (bus_start) begin
            // Repeated start is taken in any state
            next_state = ST_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_sda_oe = 1'b0;
                end
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (scl_rise && bit_cnt != BYTE_BITS) begin
                        next_shift = {shift[6:0], sda_sync[1]};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                        next_bit_cnt = 4'h0;
                        next_sda_oe = 1'b1;
                        if (state == ST_ADDR) begin
                            // Foreign addresses are left unacknowledged
                            if (shift[7:1] == SLAVE_ADDR) begin
                                next_state = ST_ADDR_ACK;
                            end else begin
                                next_state = ST_IDLE;
                                next_sda_oe = 1'b0;
                            end
                        end else if (state == ST_CMD) begin
                            next_cmd = shift;
                            next_state = ST_CMD_ACK;
                        end else begin
                            reg_write = 1'b1;
                            next_state = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (shift[0]) begin
                            next_shift = read_reg(cmd, overtemp_status,
                                                  diode_fault_status, overtemp_suppress);
                            next_sda_oe = ~next_shift[7];
                            next_state = ST_RDATA;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_state = ST_CMD;
                        end
                    end
                end
                ST_CMD_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        next_state = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == BYTE_BITS) begin
                            next_bit_cnt = 4'h0;
                            next_sda_oe = 1'b0;
                            next_state = ST_RDATA_ACK;
                        end else begin
                            next_sda_oe = ~shift[3'(4'h7 - bit_cnt)];
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    // Host acknowledge asks for the same register again
                    if (scl_rise) begin
                        next_state = sda_sync[1] ? ST_IDLE : ST_RDATA_ACK;
                    end else if (scl_fall) begin
                        next_shift = read_reg(cmd, overtemp_status,
                                              diode_fault_status, overtemp_suppress);
                        next_sda_oe = ~next_shift[7];
                        next_state = ST_RDATA;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            cmd <= 8'h00;
            sda_oe <= 1'b0;
            o_sda <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            cmd <= next_cmd;
            sda_oe <= next_sda_oe;
            o_sda <= 1'b0; // Open drain only ever pulls low
        end
    end

    assign o_sda_oe = sda_oe;

endmodule

// File: testbench/thermal_status_sva.sv
`timescale 1ns/100ps
module thermal_status_sva (
    // Watched ports
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire thermal_status_pkg::conv_result_t i_conv,
    input wire logic [7:0] o_skip_channel,
    input wire logic o_sda,
    input wire logic o_sda_oe,
    input wire logic o_overtemp_out
);
    import thermal_status_pkg::*;
    // Result aimed at a real channel
    logic take;
    assign take = i_conv.valid && (i_conv.channel inside {[3'h1:3'h6]});
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_fault_set; take && i_conv.diode_fault |=> o_skip_channel[$past(i_conv.channel)];
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault not flagged");
    property p_fault_clr; take && !i_conv.diode_fault |=> !o_skip_channel[$past(i_conv.channel)];
    endproperty
    a_fault_clr: assert property (p_fault_clr) else $error("fault not cleared");
    // Only the addressed channel may move
    property p_fault_other; take |=>
        ((o_skip_channel ^ $past(o_skip_channel)) & ~(8'h01 << $past(i_conv.channel))) == 8'h00;
    endproperty
    a_fault_other: assert property (p_fault_other) else $error("wrong fault bit moved");
    property p_reserved; (o_skip_channel & ~FAULT_BITS) == 8'h00; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved fault bit set");
    property p_ignore; i_conv.valid && !take |=> $stable(o_skip_channel); endproperty
    a_ignore: assert property (p_ignore) else $error("bad channel accepted");
    // Skip list follows results only, never the bus
    property p_skip_cause; $changed(o_skip_channel) |-> $past(take); endproperty
    a_skip_cause: assert property (p_skip_cause) else $error("skip list moved alone");
    property p_sda_low; o_sda == 1'b0; endproperty
    a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
    property p_reset; disable iff (1'b0)
        !i_nrst |=> !o_overtemp_out && !o_sda_oe && o_skip_channel == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule
bind thermal_status_reporting thermal_status_sva u_sva (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_conv(i_conv),
    .o_skip_channel(o_skip_channel),
    .o_sda(o_sda),
    .o_sda_oe(o_sda_oe),
    .o_overtemp_out(o_overtemp_out)
);

// File: testbench/smbus_host.sv
`timescale 1ns/100ps
module smbus_host (
    // Clock and bus lines
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // Both lines released while idle
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // 80 ns step; the bus clock is 180 ns with the extra data cycle
    task automatic half;
        repeat (4) @(posedge i_clk);
    endtask
    // Data moves one cycle after the clock fall, so it never looks like start or stop
    task automatic bit_x(input logic v, output logic s);
        @(posedge i_clk);
        o_sda_low <= ~v;
        half();
        o_scl <= 1'b1;
        half();
        s = i_sda;
        o_scl <= 1'b0;
    endtask
    // Start or repeated start
    task automatic start;
        @(posedge i_clk);
        o_sda_low <= 1'b0;
        half();
        o_scl <= 1'b1;
        half();
        o_sda_low <= 1'b1;
        half();
        o_scl <= 1'b0;
    endtask
    task automatic stop;
        @(posedge i_clk);
        o_sda_low <= 1'b1;
        half();
        o_scl <= 1'b1;
        half();
        o_sda_low <= 1'b0;
        half();
    endtask
    // Byte MSB first, ninth clock for the acknowledge
    task automatic xfer(input logic [7:0] tx, input logic h_ack, output logic [7:0] rx,
                        output logic d_ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], rx[i]);
        end
        bit_x(~h_ack, a);
        d_ack = ~a;
    endtask
endmodule

// File: testbench/thermal_status_reporting_tb.sv
`timescale 1ns/100ps
module thermal_status_reporting_tb;
    import thermal_status_pkg::*;
    logic clk = 1'b0;
    logic nrst, scl, sda, sda_low, sda_out, sda_oe, alarm, ack;
    logic [7:0] skip, rd, exp;
    conv_result_t conv;
    int fails = 0;
    int total_checks = 0;
    always #10 clk = ~clk;
    // Open-drain data line with pull-up
    assign sda = ~(sda_oe | sda_low);
    thermal_status_reporting uut (.i_clk(clk), .i_nrst(nrst), .i_conv(conv),
        .o_skip_channel(skip), .i_scl(scl), .i_sda(sda), .o_sda(sda_out),
        .o_sda_oe(sda_oe), .o_overtemp_out(alarm));
    smbus_host host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One result pulse, then time for the alarm to follow
    task automatic conv_put(input int ch, input logic hi, input logic flt);
        @(posedge clk);
        conv <= {1'b1, 3'(ch), hi, flt};
        @(posedge clk);
        conv <= '0;
        repeat (3) @(posedge clk);
    endtask
    task automatic addr_cmd(input logic [7:0] cmd);
        host.start();
        host.xfer({SLAVE_ADDR, 1'b0}, 1'b0, rd, ack);
        chk({7'h00, ack}, 8'h01);
        host.xfer(cmd, 1'b0, rd, ack);
    endtask
    task automatic reg_wr(input logic [7:0] cmd, input logic [7:0] data);
        addr_cmd(cmd);
        host.xfer(data, 1'b0, rd, ack);
        host.stop();
    endtask
    // Read byte, host ends with a not-acknowledge
    task automatic reg_rd(input logic [7:0] cmd);
        addr_cmd(cmd);
        host.start();
        host.xfer({SLAVE_ADDR, 1'b1}, 1'b0, rd, ack);
        chk({7'h00, ack}, 8'h01);
        host.xfer(8'hFF, 1'b0, rd, ack);
        host.stop();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        conv = '0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        reg_rd(CMD_OVERTEMP_STATUS);
        chk(rd, 8'h00);
        reg_rd(CMD_DIODE_FAULT_STATUS);
        chk(rd, 8'h00);
        reg_rd(CMD_OVERTEMP_SUPPRESS);
        chk(rd, 8'h00);
        $display("reset test done");
        exp = 8'h00;
        for (int c = 1; c <= 6; c++) begin
            conv_put(c, 1'b1, 1'b0);
            exp = exp | (OVERTEMP_BITS & (8'h01 << (c - 1)));
            reg_rd(CMD_OVERTEMP_STATUS);
            chk(rd, exp);
            chk({7'h00, alarm}, {7'h00, exp != 8'h00});
        end
        $display("limit test done");
        reg_wr(CMD_OVERTEMP_SUPPRESS, 8'h39);
        chk({7'h00, alarm}, 8'h00);
        reg_wr(CMD_OVERTEMP_SUPPRESS, 8'h38);
        chk({7'h00, alarm}, 8'h01);
        conv_put(1, 1'b0, 1'b0);
        chk({7'h00, alarm}, 8'h00);
        // Status is read-only: a write must leave it alone
        reg_wr(CMD_OVERTEMP_STATUS, 8'hFF);
        reg_rd(CMD_OVERTEMP_STATUS);
        chk(rd, 8'h38);
        $display("mask test done");
        for (int c = 0; c <= 7; c++) conv_put(c, 1'b0, 1'b1);
        chk(skip, 8'h7E);
        reg_rd(CMD_DIODE_FAULT_STATUS);
        chk(rd, 8'h7E);
        conv_put(1, 1'b1, 1'b1);
        reg_rd(CMD_OVERTEMP_STATUS);
        chk(rd, 8'h38);
        conv_put(1, 1'b0, 1'b0);
        chk(skip, 8'h7C);
        $display("fault test done");
        host.start();
        host.xfer({7'h4C, 1'b0}, 1'b0, rd, ack);
        host.stop();
        chk({7'h00, ack}, 8'h00);
        $display("address test done");
        // Receive byte reuses the last pointer; a host acknowledge repeats the register
        host.start();
        host.xfer({SLAVE_ADDR, 1'b1}, 1'b0, rd, ack);
        chk({7'h00, ack}, 8'h01);
        host.xfer(8'hFF, 1'b1, rd, ack);
        chk(rd, 8'h38);
        host.xfer(8'hFF, 1'b0, rd, ack);
        host.stop();
        chk(rd, 8'h38);
        $display("receive test done");
        // Reset in mid-run must clear the status and the skip list again
        nrst <= 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        chk(skip, 8'h00);
        chk({7'h00, alarm}, 8'h00);
        reg_rd(CMD_OVERTEMP_STATUS);
        chk(rd, 8'h00);
        $display("second reset test done");
        stop_test();
    end
    // Watchdog, well past the roughly 6k cycles the tests need
    initial begin
        #1000000;
        fails++;
        stop_test();
    end
endmodule
